// ==== sim/parallel_io_port_tb_top.sv ====
`timescale 1ns/100ps
`include "pio_cfg.svh"
module parallel_io_port_tb_top;
  import pio_pkg::*;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  periph_s periph_a = '0;
  periph_s periph_b = '0;
  logic [15:0] ext_a = 16'h0000;
  logic [15:0] ext_b = 16'h0000;
  logic [15:0] pad_in_a;
  logic [15:0] pad_in_b;
  pad_s pad_a;
  pad_s pad_b;
  logic [15:0] adc_path_en;
  logic [31:0] hrdata_s;
  pad_s pad_a_s;
  int n_errors = 0;
  int tests_run = 0;

  initial begin
    forever #20 hclk = ~hclk;
  end

  parallel_io_port u_parallel_io_port (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .periph_a(periph_a),
    .periph_b(periph_b), .pad_in_a(pad_in_a), .pad_in_b(pad_in_b), .pad_a(pad_a),
    .pad_b(pad_b), .adc_path_en(adc_path_en)
  );
  pio_pad_model u_pio_pad_model_a (.pad(pad_a), .ext_lvl(ext_a), .pad_in(pad_in_a));
  pio_pad_model u_pio_pad_model_b (.pad(pad_b), .ext_lvl(ext_b), .pad_in(pad_in_b));
  // Small variant without port A, watching the same bus cycles.
  parallel_io_port #(.port_a_present(1'b0)) u_parallel_io_port_small (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata_s), .hreadyout(), .hresp(), .periph_a(periph_a),
    .periph_b(periph_b), .pad_in_a(pad_in_a), .pad_in_b(pad_in_b), .pad_a(pad_a_s),
    .pad_b(), .adc_path_en()
  );

  // ****************************************************************
  // Bus cycles and comparison.
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input bit wr, input logic [11:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {18'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    xfer(1'b1, idx, wd, d);
  endtask : wr

  task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    xfer(1'b0, idx, 32'h0, d);
    chk(d, exp);
  endtask : rd

  task automatic settle();
    @(posedge hclk);
    @(negedge hclk);
  endtask : settle

  task automatic tally_and_finish();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (5000) @(posedge hclk);
    n_errors++;
    tally_and_finish();
  end

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk(pad_b.oe, 32'h0);
    chk({hresp, hreadyout}, 32'h1);
    rd(`PIO_IDX_A_DIR, 32'hF6C0);
    chk(hrdata_s, 32'h0);
    rd(`PIO_IDX_B_DIR, 32'hFFFF);
    rd(`PIO_IDX_B_LAT, 32'h0);
    wr(`PIO_IDX_B_LAT, 32'hFFFF1234);
    rd(`PIO_IDX_B_LAT, 32'h1234);
    ext_b <= 16'h00FF;
    rd(`PIO_IDX_B_LVL, 32'h00FF);
    wr(`PIO_IDX_B_DIR, 32'h0);
    settle();
    chk(pad_b.oe, 32'hFFFF);
    chk(pad_b.out, 32'h1234);
    wr(`PIO_IDX_B_LAT, 32'h5A5A);
    settle();
    chk(pad_b.out, 32'h5A5A);
    wr(`PIO_IDX_B_LVL, 32'hA5A5);
    rd(`PIO_IDX_B_LAT, 32'hA5A5);
    rd(`PIO_IDX_B_LVL, 32'hA5A5);
    // Bit 3 is driven by the peripheral, bit 4 is enabled but idle.
    periph_b <= '{en: 16'h0018, drive: 16'h0008, data: 16'h0018};
    settle();
    chk(pad_b.out, 32'hA5AD);
    chk(pad_b.oe, 32'hFFFF);
    rd(`PIO_IDX_B_LVL, 32'hA5AD);
    wr(`PIO_IDX_B_DIR, 32'hFFFF);
    settle();
    chk(pad_b.oe, 32'h0008);
    periph_a <= '{en: 16'h8000, drive: 16'h8000, data: 16'h0000};
    ext_a <= 16'hFFFF;
    wr(`PIO_IDX_A_LAT, 32'hFFFF);
    rd(`PIO_IDX_A_LAT, 32'hF6C0);
    wr(`PIO_IDX_A_DIR, 32'h0);
    rd(`PIO_IDX_A_DIR, 32'h0);
    settle();
    chk(pad_a.oe, 32'hF6C0);
    chk(pad_a.out, 32'hF6C0);
    chk(pad_a_s.oe, 32'h0);
    rd(`PIO_IDX_A_LVL, 32'hF6C0);
    // Analog pins stay inputs; only the digital bit 0 becomes an output.
    wr(`PIO_IDX_ANA, 32'h0006);
    rd(`PIO_IDX_B_LVL, 32'h00F9);
    wr(`PIO_IDX_B_DIR, 32'hFFFE);
    settle();
    chk(adc_path_en, 32'h0006);
    rd(12'h2D0, 32'h0);
    chk(hresp, 32'h0);
    hresetn <= 1'b0;
    @(negedge hclk);
    chk(pad_b.oe, 32'h0);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`PIO_IDX_B_DIR, 32'hFFFF);
    tally_and_finish();
  end
endmodule : parallel_io_port_tb_top

// ==== sim/pio_pad_model.sv ====
`timescale 1ns/100ps
// ****************************************************************
// Pad cells and the board around one port.
// ****************************************************************
module pio_pad_model (
  // Pad side of the port.
  input pio_pkg::pad_s pad,
  // Level that the board puts on each pin.
  input wire logic [15:0] ext_lvl,
  // Level seen by the input buffers.
  output logic [15:0] pad_in
);
  import pio_pkg::*;

  // A driven pad shows its own data; otherwise the board level wins.
  always_comb begin
    pad_in = (pad.oe & pad.out) | (~pad.oe & ext_lvl);
  end
endmodule : pio_pad_model

// ==== verilog/parallel_io_port.sv ====
`timescale 1ns/100ps
`include "pio_cfg.svh"
module parallel_io_port #(
  parameter bit port_a_present = 1'b1
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Peripherals sharing the pins.
  input pio_pkg::periph_s periph_a,
  input pio_pkg::periph_s periph_b,
  // Pad cells.
  input wire logic [15:0] pad_in_a,
  input wire logic [15:0] pad_in_b,
  output pio_pkg::pad_s pad_a,
  output pio_pkg::pad_s pad_b,
  // Converter input path enables for port B pins.
  output logic [15:0] adc_path_en
);
  import pio_pkg::*;

  // ****************************************************************
  // Per-port constants; index 0 is port A, index 1 is port B.
  // ****************************************************************
  // Port A omitted
  localparam logic [15:0] MASK_A = port_a_present ? `PIO_MASK_A : 16'h0000;
  localparam logic [1:0][15:0] MASK = {`PIO_MASK_B, MASK_A};
  localparam logic [1:0][15:0] INONLY = {`PIO_INONLY_B, `PIO_INONLY_A};
  localparam logic [1:0][15:0] RST_DIR = {`PIO_RST_B_DIR, `PIO_RST_A_DIR & MASK_A};

  periph_s per [2];
  logic [1:0][15:0] pad_in;
  assign per[0] = periph_a;
  assign per[1] = periph_b;
  assign pad_in = {pad_in_b, pad_in_a};

  logic [1:0][15:0] dir_ff;
  logic [1:0][15:0] lat_ff;
  logic [1:0][15:0] lvl_ff;
  logic [15:0] ana_ff;
  logic [1:0][15:0] nxt_dir;
  logic [1:0][15:0] nxt_lat;
  logic [15:0] nxt_ana;
  logic [1:0][15:0] ana_vec;
  logic [1:0][15:0] own;
  logic [1:0][15:0] nxt_out;
  logic [1:0][15:0] nxt_oe;
  logic [1:0][15:0] pad_out_ff;
  logic [1:0][15:0] pad_oe_ff;
  logic [15:0] adc_ff;
  logic [31:0] hrdata_ff;
  logic hready_ff;
  logic hresp_ff;
  logic wr_pend_ff;
  reg_sel_e wr_sel_ff;
  reg_sel_e rd_sel;
  logic addr_ok;
  logic [15:0] rd_val;

  assign ana_vec = {ana_ff, 16'h0000};

  // ****************************************************************
  // Bus address decode.
  // ****************************************************************
  function automatic reg_sel_e sel_of(input logic [31:0] a);
    reg_sel_e s;
    s = SEL_NONE;
    if (a[31:14] == 18'h00000 && a[1:0] == 2'b00) begin
      case (a[13:2])
        `PIO_IDX_A_DIR: s = port_a_present ? SEL_A_DIR : SEL_NONE;
        `PIO_IDX_A_LVL: s = port_a_present ? SEL_A_LVL : SEL_NONE;
        `PIO_IDX_A_LAT: s = port_a_present ? SEL_A_LAT : SEL_NONE;
        `PIO_IDX_B_DIR: s = SEL_B_DIR;
        `PIO_IDX_B_LVL: s = SEL_B_LVL;
        `PIO_IDX_B_LAT: s = SEL_B_LAT;
        `PIO_IDX_ANA: s = SEL_ANA;
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : sel_of

  assign addr_ok = hsel & hready & htrans[1];
  assign rd_sel = sel_of(haddr);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_sel_ff <= SEL_NONE;
    end else begin
      wr_pend_ff <= addr_ok & hwrite;
      wr_sel_ff <= rd_sel;
    end
  end

  // ****************************************************************
  // Register write path, applied in the data phase.
  // ****************************************************************
  // Writes are applied in the data phase, because hwdata only stands there.
  always_comb begin
    nxt_dir = dir_ff;
    nxt_lat = lat_ff;
    nxt_ana = ana_ff;
    if (wr_pend_ff) begin
      case (wr_sel_ff)
        SEL_A_DIR: nxt_dir[0] = hwdata[15:0] & MASK[0];
        // Latch write, level write hits latch
        SEL_A_LVL, SEL_A_LAT: nxt_lat[0] = hwdata[15:0] & MASK[0];
        SEL_B_DIR: nxt_dir[1] = hwdata[15:0] & MASK[1];
        SEL_B_LVL, SEL_B_LAT: nxt_lat[1] = hwdata[15:0] & MASK[1];
        SEL_ANA: nxt_ana = hwdata[15:0] & MASK[1];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_ff <= RST_DIR;
      lat_ff <= {`PIO_RST_LAT, `PIO_RST_LAT};
      ana_ff <= `PIO_RST_ANA;
    end else begin
      dir_ff <= nxt_dir;
      lat_ff <= nxt_lat;
      ana_ff <= nxt_ana;
    end
  end

  // ****************************************************************
  // Read path; a read right after a write sees the written value, except level reads, which show the sampled pins.
  // ****************************************************************
  always_comb begin
    case (rd_sel)
      SEL_A_DIR: rd_val = nxt_dir[0];
      SEL_A_LVL: rd_val = lvl_ff[0];
      SEL_A_LAT: rd_val = nxt_lat[0];
      SEL_B_DIR: rd_val = nxt_dir[1];
      SEL_B_LVL: rd_val = lvl_ff[1];
      SEL_B_LAT: rd_val = nxt_lat[1];
      SEL_ANA: rd_val = nxt_ana;
      default: rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h00000000;
      hready_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      hready_ff <= 1'b1;
      // The slave never signals an error, so the response stays OKAY.
      hresp_ff <= 1'b0;
      if (addr_ok && !hwrite) begin
        hrdata_ff <= {16'h0000, rd_val};
      end
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hready_ff;
  assign hresp = hresp_ff;

  // ****************************************************************
  // Pin sampling and pad ownership, one cell per bit.
  // ****************************************************************
  for (genvar p = 0; p < 2; p++) begin : g_port
    for (genvar b = 0; b < 16; b++) begin : g_bit
      assign own[p][b] = per[p].en[b] & per[p].drive[b] & ~INONLY[p][b] & MASK[p][b];
      // Peripheral wins muxes, port driver off
      assign nxt_out[p][b] = own[p][b] ? per[p].data[b] : nxt_lat[p][b] & MASK[p][b];
      assign nxt_oe[p][b] = own[p][b] | (~nxt_dir[p][b] & MASK[p][b]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_out_ff <= '0;
      pad_oe_ff <= '0;
    end else begin
      pad_out_ff <= nxt_out;
      pad_oe_ff <= nxt_oe;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_ff <= {`PIO_RST_LVL, `PIO_RST_LVL};
    end else begin
      lvl_ff[0] <= pad_in[0] & MASK[0] & ~ana_vec[0];
      lvl_ff[1] <= pad_in[1] & MASK[1] & ~ana_vec[1];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_ff <= 16'h0000;
    end else begin
      adc_ff <= ana_ff & dir_ff[1];
    end
  end

  assign pad_a = '{out: pad_out_ff[0], oe: pad_oe_ff[0]};
  assign pad_b = '{out: pad_out_ff[1], oe: pad_oe_ff[1]};
  assign adc_path_en = adc_ff;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic seen_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_ff <= 1'b0;
    end else begin
      seen_ff <= 1'b1;
    end
  end

  sequence rd_addr_s(logic [11:0] idx);
    addr_ok && !hwrite && haddr == {18'h00000, idx, 2'b00};
  endsequence

  sequence wr_addr_s(logic [11:0] idx);
    addr_ok && hwrite && haddr == {18'h00000, idx, 2'b00};
  endsequence

  a_dir_reset_input: assert property (
    !seen_ff |-> dir_ff == RST_DIR && pad_oe_ff == '0)
    else $error("direction not input after reset");

  a_periph_owns_pad: assert property (
    own[1] != 16'h0000 |=> ((pad_b.out ^ $past(periph_b.data)) & $past(own[1])) == 16'h0000
      && (pad_b.oe & $past(own[1])) == $past(own[1]))
    else $error("peripheral lost pad ownership");

  a_idle_periph_port: assert property (
    (periph_b.en & ~periph_b.drive) != 16'h0000 |=>
      ((pad_b.oe ^ ~$past(nxt_dir[1])) & $past(periph_b.en & ~periph_b.drive)) == 16'h0000
      && ((pad_b.out ^ $past(nxt_lat[1])) & $past(periph_b.en & ~periph_b.drive)) == 16'h0000)
    else $error("idle peripheral blocked port");

  a_inonly_no_arb: assert property (
    1'b1 |=> (pad_a.oe & `PIO_INONLY_A) == (~$past(nxt_dir[0]) & MASK[0] & `PIO_INONLY_A))
    else $error("input-only pin arbitrated");

  a_latch_readback: assert property (
    rd_addr_s(`PIO_IDX_B_LAT) |=> hrdata == {16'h0000, lat_ff[1]})
    else $error("latch readback wrong");

  a_latch_write: assert property (
    wr_addr_s(`PIO_IDX_B_LAT) ##1 1'b1 |=> lat_ff[1] == $past(hwdata[15:0]))
    else $error("latch write missed");

  a_level_wr_latch: assert property (
    wr_addr_s(`PIO_IDX_B_LVL) ##1 1'b1 |=> lat_ff[1] == $past(hwdata[15:0]))
    else $error("pin level write missed latch");

  a_level_read_pins: assert property (
    rd_addr_s(`PIO_IDX_B_LVL) |=> hrdata[15:0] == ($past(pad_in_b, 2) & ~$past(ana_ff, 2)))
    else $error("pin level read wrong");

  a_unimpl_zero: assert property (
    ((dir_ff[0] | lat_ff[0] | lvl_ff[0]) & ~MASK[0]) == 16'h0000 && hrdata[31:16] == 16'h0000)
    else $error("unimplemented bit nonzero");

  a_analog_low: assert property (
    ##1 (lvl_ff[1] & $past(ana_ff)) == 16'h0000)
    else $error("analog pin read high");

  a_adc_digital: assert property (
    ##1 (adc_path_en & ~$past(dir_ff[1])) == 16'h0000
      && (adc_path_en & ~$past(ana_ff)) == 16'h0000)
    else $error("digital input reached converter");

  a_port_a_absent: assert property (
    !port_a_present |-> pad_a.oe == 16'h0000 && lvl_ff[0] == 16'h0000 && dir_ff[0] == 16'h0000)
    else $error("absent port A active");

  a_latch_to_pad: assert property (
    wr_addr_s(`PIO_IDX_B_LAT) ##1 (own[1] == 16'h0000 && dir_ff[1] == 16'h0000)
      |=> pad_b.out == $past(hwdata[15:0]) && pad_b.oe == 16'hFFFF)
    else $error("pad did not follow latch");

endmodule : parallel_io_port

// ==== verilog/pio_cfg.svh ====
`ifndef PIO_CFG_SVH
`define PIO_CFG_SVH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define PIO_IDX_A_DIR 12'h2C0
`define PIO_IDX_A_LVL 12'h2C2
`define PIO_IDX_A_LAT 12'h2C4
`define PIO_IDX_B_DIR 12'h2C6
`define PIO_IDX_B_LVL 12'h2C8
`define PIO_IDX_B_LAT 12'h2CB
`define PIO_IDX_ANA 12'h2A8

// ****************************************************************
// Reset values and implemented-bit masks.
// ****************************************************************
`define PIO_RST_A_DIR 16'hF6C0
`define PIO_RST_B_DIR 16'hFFFF
`define PIO_RST_LVL 16'h0000
`define PIO_RST_LAT 16'h0000
`define PIO_RST_ANA 16'h0000
`define PIO_MASK_A 16'hF6C0
`define PIO_MASK_B 16'hFFFF
`define PIO_INONLY_A 16'h8000
`define PIO_INONLY_B 16'h0000

`endif

// ==== verilog/pio_pkg.sv ====
package pio_pkg;

  // Signals a peripheral presents for the sixteen pins of one port.
  typedef struct packed {
    logic [15:0] en;
    logic [15:0] drive;
    logic [15:0] data;
  } periph_s;

  // Output data and output enable towards the pad cells of one port.
  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } pad_s;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_A_DIR, SEL_A_LVL, SEL_A_LAT,
    SEL_B_DIR, SEL_B_LVL, SEL_B_LAT, SEL_ANA
  } reg_sel_e;

endpackage : pio_pkg
